// ---- rtl/idfs_map.vh ----
// Constants for the isolated-side fault status bank: field positions, reset values.
// Assumes inclusion by the status bank module only.
`ifndef IDFS_MAP_VH
`define IDFS_MAP_VH
`define IDFS_STAT_RESET        16'h0000
// Status A fields
`define IDFS_A_SUPPLY_LOW      7
`define IDFS_A_CLAMP           6
`define IDFS_A_SW_OVERTEMP     5
`define IDFS_A_REG_ILIMIT      3
`define IDFS_A_SHORT           2
`define IDFS_A_OVERCURRENT     1
`define IDFS_A_SAT_LOSS        0
// Status B fields
`define IDFS_B_VCE_LEVEL       14
`define IDFS_B_WARM            13
`define IDFS_B_SHUTDOWN        12
`define IDFS_B_ALARM_OR        10
`define IDFS_B_WARNING_OR      9
`define IDFS_B_SELFTEST        8
`define IDFS_B_CLK_MISMATCH    7
`define IDFS_B_CFG_INTEGRITY   6
`define IDFS_B_TRIM_INTEGRITY  5
`define IDFS_B_READY           0
`endif

// ---- rtl/idfs_status_bank.v ----
// Isolated-side fault status bank: two read-only 16-bit status registers.
// Assumes fault inputs synchronous to i_clock; register reads arrive as strobes
// from the serial interface decoder.
//
// Functional notes
// RULE_01 - Supply-low flag bit 7 sets on undervoltage unless disable bit set.
// RULE_02 - Collector-clamp flag bit 6 sets on clamp soft turn-off when enabled.
// RULE_03 - Switch over-temp bit 5 sets when enabled inputs one/three/five over threshold.
// RULE_04 - Regulator current-limit bit 3 sets while regulator is in current limit.
// RULE_05 - Short-circuit bit 2 sets when enabled inputs two/four/six exceed threshold.
// RULE_06 - Over-current bit 1 sets when enabled inputs two/four/six exceed threshold.
// RULE_07 - Saturation-loss bit 0 sets when saturation-sense pin exceeds threshold.
// RULE_08 - Status B bit 14 shows present collector-emitter voltage level.
// RULE_09 - Warm-warning bit 13 sets when die temperature exceeds warning threshold.
// RULE_10 - Warm-warning clears only after temperature drops then host reads status B.
// RULE_11 - Thermal-shutdown bit 12 sets when die temperature exceeds shutdown threshold.
// RULE_12 - Bit 10 is the OR of faults routed to the alarm pin.
// RULE_13 - Bit 9 is the OR of faults routed to the warning pin.
// RULE_14 - Self-test bit 8 sets if latent self-test fails at power-up.
// RULE_15 - Clock-mismatch bit 7 sets when barrier clock disagrees with local clock.
// RULE_16 - Config-integrity bit 6 sets on config change during active mode.
// RULE_17 - Config-integrity also sets on scratch or reserved writes in configuration two.
// RULE_18 - Status B bit 0 reads one once isolated side is ready.
// RULE_19 - Both registers read-only, reset to zero, host writes ignored.
`timescale 1ns/1ps
`include "idfs_map.vh"

module idfs_status_bank (
   // Clock and reset
   input  wire        i_clock,
   input  wire        i_reset,
   // Configuration bits
   input  wire        i_iso_supply_low_disable,
   input  wire        i_collector_clamp_enable,
   input  wire [2:0]  i_temp_input_enable,
   input  wire [2:0]  i_current_input_enable,
   // Raw detector levels
   input  wire        i_supply_below_threshold,
   input  wire        i_clamp_soft_turnoff,
   input  wire [2:0]  i_temp_over_threshold,
   input  wire        i_regulator_in_limit,
   input  wire [2:0]  i_current_over_short,
   input  wire [2:0]  i_current_over_oc,
   input  wire        i_saturation_over_threshold,
   input  wire        i_collector_voltage_level,
   input  wire        i_die_over_warning,
   input  wire        i_die_over_shutdown,
   input  wire [15:0] i_alarm_route_mask,
   input  wire [15:0] i_warning_route_mask,
   input  wire        i_selftest_failed,
   input  wire        i_clock_mismatch,
   input  wire        i_trim_integrity_error,
   input  wire        i_iso_side_ready,
   // Mode and configuration events
   input  wire        i_active_mode,
   input  wire        i_config_two_state,
   input  wire        i_config_bit_changed,
   input  wire        i_scratch_or_reserved_write,
   // Register access strobes
   input  wire        i_read_status_a,
   input  wire        i_read_status_b,
   input  wire        i_write_status,
   // Read data and fault pins
   output reg  [15:0] o_read_data,
   output wire        o_alarm_out_n,
   output wire        o_warning_out_n
);

   ////////////////////////////////////////////////////////////////////////////////
   // Status registers and their next values
   reg  [15:0] status_a_reg;
   reg  [15:0] status_b_reg;
   reg  [15:0] read_data_next;
   wire [15:0] status_a_next;
   wire [15:0] status_b_next;

   // Per-bit set terms of status A
   wire [15:0] set_a;

   // Per-bit controls of status B: set, clear, live select and live value
   wire [15:0] set_b;
   wire [15:0] clear_b;
   wire [15:0] live_sel_b;
   wire [15:0] live_val_b;

   // Qualified fault conditions
   wire        supply_low_hit;
   wire        clamp_hit;
   wire        switch_hot_hit;
   wire        regulator_limit_hit;
   wire        short_hit;
   wire        overcurrent_hit;
   wire        saturation_hit;
   wire        warm_hit;
   wire        warm_release;
   wire        shutdown_hit;
   wire        selftest_hit;
   wire        clock_mismatch_hit;
   wire        config_active_hit;
   wire        config_two_hit;
   wire        config_integrity_hit;
   wire        trim_integrity_hit;

   // Sticky flags that feed the pin summaries
   wire        warm_flag;
   wire        shutdown_flag;
   wire        selftest_flag;
   wire        clock_mismatch_flag;
   wire        config_integrity_flag;

   // Fault summaries feeding the two pins
   wire [15:0] fault_vector;
   wire        alarm_or;
   wire        warning_or;

   genvar      bit_idx;

   ////////////////////////////////////////////////////////////////////////////////
   // Any enabled input of a three-input group over its threshold
   function any_enabled;
      input [2:0] hit;
      input [2:0] en;
      begin
         any_enabled = |(hit & en);
      end
   endfunction

   // Next value of one status bit; a set beats a clear in the same cycle
   function flag_next;
      input cur;
      input set;
      input clr;
      input live_sel;
      input live_val;
      begin
         if (live_sel) begin
            flag_next = live_val;
         end else if (set) begin
            flag_next = 1'b1;
         end else if (clr) begin
            flag_next = 1'b0;
         end else begin
            flag_next = cur;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Status A conditions: supply and clamp
   assign supply_low_hit      = i_supply_below_threshold & ~i_iso_supply_low_disable; // RULE_01
   assign clamp_hit           = i_clamp_soft_turnoff & i_collector_clamp_enable; // RULE_02

   // Status A conditions: switch temperature, regulator and current inputs
   assign switch_hot_hit      = any_enabled(i_temp_over_threshold,
                                            i_temp_input_enable); // RULE_03
   assign regulator_limit_hit = i_regulator_in_limit; // RULE_04
   assign short_hit           = any_enabled(i_current_over_short,
                                            i_current_input_enable); // RULE_05
   assign overcurrent_hit     = any_enabled(i_current_over_oc,
                                            i_current_input_enable); // RULE_06

   // Status A conditions: saturation sense
   assign saturation_hit      = i_saturation_over_threshold; // RULE_07

   // Status B conditions: die temperature
   assign warm_hit            = i_die_over_warning; // RULE_09
   assign warm_release        = i_read_status_b & ~i_die_over_warning; // RULE_10
   assign shutdown_hit        = i_die_over_shutdown; // RULE_11

   // Status B conditions: self-test, clock and configuration integrity
   assign selftest_hit         = i_selftest_failed; // RULE_14
   assign clock_mismatch_hit   = i_clock_mismatch; // RULE_15
   assign config_active_hit    = i_active_mode & i_config_bit_changed; // RULE_16
   assign config_two_hit       = i_config_two_state & i_scratch_or_reserved_write; // RULE_17
   assign config_integrity_hit = config_active_hit | config_two_hit;
   assign trim_integrity_hit   = i_trim_integrity_error & (i_active_mode | i_config_two_state);

   ////////////////////////////////////////////////////////////////////////////////
   // Status A set terms; bit 4 and the upper byte stay zero
   assign set_a[15:8]                 = 8'h00;
   assign set_a[`IDFS_A_SUPPLY_LOW]   = supply_low_hit;
   assign set_a[`IDFS_A_CLAMP]        = clamp_hit;
   assign set_a[`IDFS_A_SW_OVERTEMP]  = switch_hot_hit;
   assign set_a[4]                    = 1'b0;
   assign set_a[`IDFS_A_REG_ILIMIT]   = regulator_limit_hit;
   assign set_a[`IDFS_A_SHORT]        = short_hit;
   assign set_a[`IDFS_A_OVERCURRENT]  = overcurrent_hit;
   assign set_a[`IDFS_A_SAT_LOSS]     = saturation_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // Status B set terms: die temperature
   assign set_b[15]                    = 1'b0;
   assign set_b[`IDFS_B_VCE_LEVEL]     = 1'b0;
   assign set_b[`IDFS_B_WARM]          = warm_hit;
   assign set_b[`IDFS_B_SHUTDOWN]      = shutdown_hit;
   assign set_b[11]                    = 1'b0;
   assign set_b[`IDFS_B_ALARM_OR]      = 1'b0;
   assign set_b[`IDFS_B_WARNING_OR]    = 1'b0;

   // Status B set terms: self-test, clock and integrity; bits 4 to 1 stay zero
   assign set_b[`IDFS_B_SELFTEST]       = selftest_hit;
   assign set_b[`IDFS_B_CLK_MISMATCH]   = clock_mismatch_hit;
   assign set_b[`IDFS_B_CFG_INTEGRITY]  = config_integrity_hit;
   assign set_b[`IDFS_B_TRIM_INTEGRITY] = trim_integrity_hit;
   assign set_b[4:1]                    = 4'h0;
   assign set_b[`IDFS_B_READY]          = 1'b0;

   // Status B clear: only the warm warning is cleared by a read
   assign clear_b[15:14]         = 2'h0;
   assign clear_b[`IDFS_B_WARM]  = warm_release; // RULE_10
   assign clear_b[12:0]          = 13'h0000;

   // Status B live mirror select
   assign live_sel_b[15]                  = 1'b0;
   assign live_sel_b[`IDFS_B_VCE_LEVEL]   = 1'b1;
   assign live_sel_b[13:11]               = 3'h0;
   assign live_sel_b[`IDFS_B_ALARM_OR]    = 1'b1;
   assign live_sel_b[`IDFS_B_WARNING_OR]  = 1'b1;
   assign live_sel_b[8:1]                 = 8'h00;
   assign live_sel_b[`IDFS_B_READY]       = 1'b1;

   // Status B live mirror values
   assign live_val_b[15]                  = 1'b0;
   assign live_val_b[`IDFS_B_VCE_LEVEL]   = i_collector_voltage_level; // RULE_08
   assign live_val_b[13:11]               = 3'h0;
   assign live_val_b[`IDFS_B_ALARM_OR]    = alarm_or; // RULE_12
   assign live_val_b[`IDFS_B_WARNING_OR]  = warning_or; // RULE_13
   assign live_val_b[8:1]                 = 8'h00;
   assign live_val_b[`IDFS_B_READY]       = i_iso_side_ready; // RULE_18

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky flags routed to the pin summaries
   assign warm_flag             = status_b_reg[`IDFS_B_WARM];
   assign shutdown_flag         = status_b_reg[`IDFS_B_SHUTDOWN];
   assign selftest_flag         = status_b_reg[`IDFS_B_SELFTEST];
   assign clock_mismatch_flag   = status_b_reg[`IDFS_B_CLK_MISMATCH];
   assign config_integrity_flag = status_b_reg[`IDFS_B_CFG_INTEGRITY];

   // Fault vector: status A low byte, then the status B sticky faults except trim integrity
   assign fault_vector[7:0]   = status_a_reg[7:0];
   assign fault_vector[8]     = config_integrity_flag;
   assign fault_vector[9]     = clock_mismatch_flag;
   assign fault_vector[10]    = selftest_flag;
   assign fault_vector[11]    = shutdown_flag;
   assign fault_vector[12]    = warm_flag;
   assign fault_vector[15:13] = 3'h0;

   assign alarm_or            = |(fault_vector & i_alarm_route_mask); // RULE_12
   assign warning_or          = |(fault_vector & i_warning_route_mask); // RULE_13

   ////////////////////////////////////////////////////////////////////////////////
   // Per-bit next state
   generate
      for (bit_idx = 0; bit_idx < 16; bit_idx = bit_idx + 1) begin : g_status_bits
         // Status A bit: sticky only
         assign status_a_next[bit_idx] = flag_next(status_a_reg[bit_idx], set_a[bit_idx],
                                                   1'b0, 1'b0, 1'b0);
         // Status B bit: sticky, read-cleared or live
         assign status_b_next[bit_idx] = flag_next(status_b_reg[bit_idx], set_b[bit_idx],
                                                   clear_b[bit_idx], live_sel_b[bit_idx],
                                                   live_val_b[bit_idx]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Read data select; status A wins when both strobes arrive together
   always @* begin
      read_data_next = o_read_data;
      if (i_read_status_a) begin
         read_data_next = status_a_reg;
      end else if (i_read_status_b) begin
         read_data_next = status_b_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status A register
   always @(posedge i_clock) begin
      if (i_reset) begin
         status_a_reg <= `IDFS_STAT_RESET; // RULE_19
      end else begin
         status_a_reg <= status_a_next;
      end
   end

   // Status B register; i_write_status deliberately has no path here
   always @(posedge i_clock) begin
      if (i_reset) begin
         status_b_reg <= `IDFS_STAT_RESET; // RULE_19
      end else begin
         status_b_reg <= status_b_next;
      end
   end

   // Read data register, held until the next read strobe
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_read_data <= `IDFS_STAT_RESET;
      end else begin
         o_read_data <= read_data_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Active-low fault pins follow the registered OR bits
   assign o_alarm_out_n   = ~status_b_reg[`IDFS_B_ALARM_OR];
   assign o_warning_out_n = ~status_b_reg[`IDFS_B_WARNING_OR];

endmodule

// ---- bench/idfs_status_bank_asserts.sv ----
// Checker for the isolated-side fault status bank ports.
// Assumes it is bound onto idfs_status_bank, one clock domain.
`timescale 1ns/1ps
module idfs_asserts (
   input logic        i_clock, i_reset, i_read_status_a, i_read_status_b,
   input logic        i_saturation_over_threshold, i_iso_side_ready,
   input logic        i_collector_voltage_level, i_die_over_warning,
   input logic        o_alarm_out_n, o_warning_out_n,
   input logic [15:0] o_read_data
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   sequence s_rd_b; i_read_status_b && !i_read_status_a && !$past(i_reset); endsequence
   sequence s_clr; (s_rd_b and !i_die_over_warning) ##1 !i_die_over_warning; endsequence
   a_sat_flag_set: assert property (i_read_status_a && !$past(i_reset) &&
      $past(i_saturation_over_threshold) |=> o_read_data[0]) else $error("sat flag missing");
   a_rsvd_b_zero: assert property (s_rd_b |=> o_read_data[4:1] == 0 &&
      !o_read_data[15] && !o_read_data[11]) else $error("reserved bit set");
   a_ready_mirror: assert property (s_rd_b |=>
      o_read_data[0] == $past(i_iso_side_ready, 2)) else $error("ready bit wrong");
   a_vce_mirror: assert property (s_rd_b |=>
      o_read_data[14] == $past(i_collector_voltage_level, 2)) else $error("vce bit wrong");
   a_data_hold: assert property (!i_read_status_a && !i_read_status_b |=>
      $stable(o_read_data)) else $error("read data moved");
   a_warm_keep: assert property (s_rd_b and (i_die_over_warning &&
      $past(i_die_over_warning)) |=> o_read_data[13]) else $error("warm flag lost");
   a_warm_clear: assert property (s_clr ##1 s_rd_b |=> !o_read_data[13])
      else $error("warm flag stuck");
   a_reset_clear: assert property (disable iff (1'h0) i_reset |=> o_read_data == 0 &&
      o_alarm_out_n && o_warning_out_n) else $error("reset values wrong");
endmodule
bind idfs_status_bank idfs_asserts chk (.*);

// ---- bench/idfs_host.sv ----
// Host model issuing status reads and writes.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ps
module idfs_host (
   input  wire        i_clock,
   input  wire [15:0] i_read_data,
   output logic       o_read_a = 1'h0,
   output logic       o_read_b = 1'h0,
   output logic       o_write  = 1'h0
);
   task rd(input bit b, output logic [15:0] d);
      @(negedge i_clock);
      {o_read_b, o_read_a} = {b, !b};
      @(negedge i_clock);
      d = i_read_data;
      {o_read_b, o_read_a} = 2'h0;
   endtask
   task wr;
      @(negedge i_clock);
      o_write = 1'h1;
      @(negedge i_clock);
      o_write = 1'h0;
   endtask
endmodule

// ---- bench/idfs_status_bank_tb_top.sv ----
// Testbench for the fault status bank.
// Assumes idfs_host and the bound checker are compiled first.
`timescale 1ns/1ps
module idfs_status_bank_tb_top;
   logic i_clock = 0, i_reset = 1, i_iso_supply_low_disable = 0, i_collector_clamp_enable = 0;
   logic i_supply_below_threshold = 0, i_clamp_soft_turnoff = 0, i_regulator_in_limit = 0;
   logic i_saturation_over_threshold = 0, i_collector_voltage_level = 0, i_active_mode = 0;
   logic i_die_over_warning = 0, i_die_over_shutdown = 0, i_selftest_failed = 0;
   logic i_clock_mismatch = 0, i_trim_integrity_error = 0, i_iso_side_ready = 0;
   logic i_config_two_state = 0, i_config_bit_changed = 0, i_scratch_or_reserved_write = 0;
   logic [2:0] i_temp_input_enable = 0, i_current_input_enable = 0, i_temp_over_threshold = 0;
   logic [2:0] i_current_over_short = 0, i_current_over_oc = 0;
   logic [15:0] i_alarm_route_mask = 0, i_warning_route_mask = 0, o_read_data, d;
   logic i_read_status_a, i_read_status_b, i_write_status, o_alarm_out_n, o_warning_out_n;
   int n_mismatch = 0, tests_run = 0;
   idfs_status_bank dut (.*);
   idfs_host host (.i_clock(i_clock), .i_read_data(o_read_data), .o_read_a(i_read_status_a),
      .o_read_b(i_read_status_b), .o_write(i_write_status));
   always #2 i_clock = ~i_clock;
   ////////////////////////////////////////////////////////////////////////////
   task ck(string n, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task rst;
      i_reset = 1;
      repeat (3) @(negedge i_clock);
      i_reset = 0;
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Tests need well under 200 cycles
   initial begin
      #20000;
      n_mismatch++;
      results;
   end
   initial begin
      rst;
      host.rd(0, d); ck("status_a", 16'h0000, d);
      host.rd(1, d); ck("status_b", 16'h0000, d);
      ck("pins", 16'h0003, {o_alarm_out_n, o_warning_out_n});
      $display("reset test done");
      {i_iso_supply_low_disable, i_supply_below_threshold, i_regulator_in_limit} = 3'h7;
      {i_saturation_over_threshold, i_clamp_soft_turnoff} = 2'h3;
      {i_temp_input_enable, i_temp_over_threshold, i_current_input_enable} = 9'h04a;
      {i_current_over_short, i_current_over_oc} = 6'h14;
      host.rd(0, d); ck("status_a", 16'h002d, d);
      {i_iso_supply_low_disable, i_collector_clamp_enable, i_current_over_oc} = 5'h0a;
      host.rd(0, d); ck("status_a", 16'h00ef, d);
      host.wr;
      host.rd(0, d); ck("status_a", 16'h00ef, d);
      $display("status a test done");
      {i_collector_voltage_level, i_iso_side_ready, i_selftest_failed} = 3'h7;
      {i_clock_mismatch, i_die_over_shutdown, i_active_mode} = 3'h7;
      i_alarm_route_mask = 16'h0001;
      i_config_bit_changed = 1;
      @(negedge i_clock) i_config_bit_changed = 0;
      repeat (2) @(negedge i_clock);
      host.rd(1, d); ck("status_b", 16'h55c1, d);
      ck("pins", 16'h0001, {o_alarm_out_n, o_warning_out_n});
      $display("status b test done");
      {i_active_mode, i_config_two_state} = 2'h1;
      rst;
      i_scratch_or_reserved_write = 1;
      @(negedge i_clock) i_scratch_or_reserved_write = 0;
      i_warning_route_mask = 16'h1000;
      host.rd(1, d); ck("status_b", 16'h55c1, d);
      i_die_over_warning = 1;
      repeat (2) @(negedge i_clock);
      host.rd(1, d); ck("status_b", 16'h77c1, d);
      host.rd(1, d); ck("status_b", 16'h77c1, d);
      i_die_over_warning = 0;
      host.rd(1, d); ck("status_b", 16'h77c1, d);
      host.rd(1, d); ck("status_b", 16'h55c1, d);
      $display("warning test done");
      i_trim_integrity_error = 1;
      host.rd(1, d); ck("status_b", 16'h55e1, d);
      $display("trim test done");
      results;
   end
endmodule
